// ===== testbench/hwcfg_host_model.sv
// Purpose: host side of the io write path for hwcfg_hostload
// Assumes: one-cycle write pulses, driven at the falling edge
// Notes: a released bus shows the inverse of the last value, never the stale one
`timescale 1ns/1ps
module hwcfg_host_model (
  input wire logic clk_sys,
  input wire logic cfg_busy,
  output logic io_wr,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  logic [15:0] base = 16'h0120;
  initial begin
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // waits while the loader is busy, so no byte is lost to a full fifo
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cfg_busy === 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge clk_sys);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  task automatic unlock(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] keyb);
    repeat (32) wr(16'h0279, keyb);
    wr(16'h0279, 8'h15);
    wr(16'h0279, 8'h02);
    wr(16'h0279, 8'h47);
    wr(16'h0279, hi);
    wr(16'h0279, lo);
    wr(16'h0279, 8'h33);
    wr(16'h0279, 8'h01);
    wr(16'h0279, 8'h79);
    base = {hi, lo};
  endtask
  task automatic start();
    wr(base + 16'h0005, 8'h57);
    wr(base + 16'h0005, 8'hAA);
    wr(base + 16'h0005, 8'h00);
    wr(base + 16'h0005, 8'h40);
  endtask
  // image starts with the first config byte: no eeprom header
  task automatic send_cfg(input logic [7:0] m, input logic [7:0] g, input logic [7:0] c, input logic [7:0] dl,
                          input logic [23:0] irq, input logic [15:0] dma);
    logic [7:0] img [19];
    img = '{8'h00, 8'h03, m, g, c, 8'h20, 8'h04, 8'h08, 8'h10, 8'h80, 8'h00, 8'h00, dl, 8'h48,
            irq[7:0], irq[15:8], irq[23:16], dma[7:0], dma[15:8]};
    for (int i = 0; i < 19; i++) wr(base + 16'h0005, img[i]);
  endtask
  task automatic finish();
    wr(base + 16'h0006, 8'h00);
  endtask
  task automatic apply();
    wr(base + 16'h0005, 8'h5A);
  endtask
endmodule

// ===== testbench/hwcfg_hostload_assertions.sv
// Purpose: port checks of hwcfg_hostload
// Assumes: synchronous active high reset
// Notes: config outputs may move only just after a scan
`timescale 1ns/1ps
module hwcfg_hostload_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic periph_rd,
  input wire logic serial_port_enable,
  input wire logic synth_vol_wr,
  input wire logic cfg_busy,
  input wire logic [15:0] control_port_base,
  input wire logic download_active,
  input wire logic host_data_drive_en,
  input wire logic dsp_port_on_mid_pins,
  input wire logic mid_pins_serial,
  input wire logic high_pins_wavetable,
  input wire logic alt_line_vol_wr,
  input wire logic internal_synth_enable,
  input wire logic ctrl_or_addr2_pin_is_addr,
  input wire logic [3:0] periph_decode_len,
  input wire logic [23:0] irq_map,
  input wire logic [11:0] dma_map
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence scan_near_s;
    $past(cfg_busy) || $past(cfg_busy, 2) || $past(cfg_busy, 3) || $past(cfg_busy, 4);
  endsequence
  sequence key_wr_s;
    $past(io_wr) && ($past(io_addr) == 16'h0279);
  endsequence
  host_drive_a: assert property (
    host_data_drive_en == (periph_rd && !dsp_port_on_mid_pins && !high_pins_wavetable))
    else $error("host drive wrong");
  serial_pins_a: assert property (mid_pins_serial == (dsp_port_on_mid_pins && serial_port_enable))
    else $error("serial pins wrong");
  decode_len_a: assert property (periph_decode_len == (ctrl_or_addr2_pin_is_addr ? 4'h8 : 4'h4))
    else $error("decode length wrong");
  base_set_a: assert property (!$stable(control_port_base) |-> key_wr_s) else $error("base moved");
  dl_enter_a: assert property (
    $rose(download_active) |-> $past(io_wr) && $past(io_addr) == control_port_base + 16'h0005)
    else $error("download entered wrongly");
  dl_leave_a: assert property (
    $fell(download_active) |-> $past(io_wr) && $past(io_wdata) == 8'h00
    && $past(io_addr) == control_port_base + 16'h0006) else $error("download left wrongly");
  alt_line_a: assert property (alt_line_vol_wr |-> synth_vol_wr) else $error("alt line write unasked");
  irq_hold_a: assert property (!$stable(irq_map) |-> scan_near_s) else $error("irq map moved");
  dma_hold_a: assert property (!$stable(dma_map) |-> scan_near_s) else $error("dma map moved");
  synth_hold_a: assert property (!$stable(internal_synth_enable) |-> scan_near_s)
    else $error("synth enable moved");
endmodule
bind hwcfg_hostload hwcfg_hostload_assertions CHK (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_wr(io_wr),
  .io_addr(io_addr), .io_wdata(io_wdata), .periph_rd(periph_rd), .serial_port_enable(serial_port_enable),
  .synth_vol_wr(synth_vol_wr), .cfg_busy(cfg_busy), .control_port_base(control_port_base),
  .download_active(download_active), .host_data_drive_en(host_data_drive_en),
  .dsp_port_on_mid_pins(dsp_port_on_mid_pins), .mid_pins_serial(mid_pins_serial),
  .high_pins_wavetable(high_pins_wavetable), .alt_line_vol_wr(alt_line_vol_wr),
  .internal_synth_enable(internal_synth_enable), .ctrl_or_addr2_pin_is_addr(ctrl_or_addr2_pin_is_addr),
  .periph_decode_len(periph_decode_len), .irq_map(irq_map), .dma_map(dma_map));

// ===== testbench/hwcfg_hostload_tb.sv
// Purpose: self-checking bench of hwcfg_hostload
// Assumes: inputs change at the falling edge
// Notes: five configs, each followed by a volume button test
`timescale 1ns/1ps
module hwcfg_hostload_tb;
  localparam logic [7:0] KEYB = 8'h6A; // arbitrary key byte
  localparam logic [7:0] OWN_CODE = 8'h5C; // arbitrary code base
  logic clk_sys = 1'b0, sys_rst = 1'b1, io_wr, periph_rd = 1'b0, serial_port_enable = 1'b0, synth_vol_wr = 1'b0;
  logic vol_up_n = 1'b1, vol_down_n = 1'b1, vol_mute_n = 1'b1;
  logic [15:0] io_addr, control_port_base;
  logic [7:0] io_wdata;
  logic download_active, cfg_busy, host_data_drive_en, dsp_port_on_mid_pins, mid_pins_serial, high_pins_wavetable;
  logic alt_line_vol_wr, internal_synth_enable, patch_load_enable, ctrl_or_addr2_pin_is_addr, volume_muted;
  logic vol_up_pulse, vol_down_pulse;
  logic [3:0] periph_decode_len;
  logic [23:0] irq_map, prev_irq = 24'hFCB975;
  logic [11:0] dma_map;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  logic [7:0] tg [5] = '{8'hAC, 8'h10, 8'h48, 8'hE4, 8'h40};
  logic [7:0] tc [5] = '{8'h11, 8'h5C, 8'h11, 8'h5C, 8'h5C};
  logic [7:0] td [5] = '{8'h08, 8'h00, 8'h08, 8'h00, 8'h00};
  logic [7:0] tm [5] = '{8'h84, 8'h84, 8'h84, 8'h84, 8'h80};
  hwcfg_host_model HOST (.clk_sys(clk_sys), .cfg_busy(cfg_busy), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata));
  hwcfg_hostload DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .key_value(32'h00000000), .key_byte_expected(KEYB), .own_code_base(OWN_CODE), .periph_rd(periph_rd),
    .serial_port_enable(serial_port_enable), .synth_vol_wr(synth_vol_wr), .vol_up_n(vol_up_n),
    .vol_down_n(vol_down_n), .vol_mute_n(vol_mute_n), .control_port_base(control_port_base),
    .download_active(download_active), .cfg_busy(cfg_busy), .host_data_drive_en(host_data_drive_en),
    .dsp_port_on_mid_pins(dsp_port_on_mid_pins), .mid_pins_serial(mid_pins_serial),
    .high_pins_wavetable(high_pins_wavetable), .alt_line_vol_wr(alt_line_vol_wr),
    .internal_synth_enable(internal_synth_enable), .patch_load_enable(patch_load_enable),
    .ctrl_or_addr2_pin_is_addr(ctrl_or_addr2_pin_is_addr), .periph_decode_len(periph_decode_len),
    .irq_map(irq_map), .dma_map(dma_map), .volume_muted(volume_muted), .vol_up_pulse(vol_up_pulse),
    .vol_down_pulse(vol_down_pulse));
  always #5 clk_sys = ~clk_sys;
  // well above the roughly eight hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic press(input logic u, input logic d, input logic m);
    @(negedge clk_sys);
    vol_up_n = ~u;
    vol_down_n = ~d;
    vol_mute_n = ~m;
    repeat (4) @(negedge clk_sys);
    vol_up_n = 1'b1;
    vol_down_n = 1'b1;
    vol_mute_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  // one-cycle tap: pulse stands only until the next edge
  task automatic tap(input logic u, input logic d, input logic m, input logic eu, input logic ed);
    @(negedge clk_sys);
    {vol_up_n, vol_down_n, vol_mute_n} = ~{u, d, m};
    #1;
    chk(vol_up_pulse, eu);
    chk(vol_down_pulse, ed);
    @(negedge clk_sys);
    chk(vol_up_pulse || vol_down_pulse, 1'b0);
    {vol_up_n, vol_down_n, vol_mute_n} = 3'h7;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic t_rerst();
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
  endtask
  task automatic t_reset();
    chk(control_port_base, 16'h0120);
    chk(irq_map, 24'hFCB975);
    chk(dma_map, 12'h310);
    chk(periph_decode_len, 4'h4);
    chk(internal_synth_enable, 1'b0);
  endtask
  task automatic t_unlock();
    HOST.unlock(8'h03, 8'h00, KEYB);
    chk(control_port_base, 16'h0300);
  endtask
  task automatic t_cfg(input logic [7:0] g, input logic [7:0] c, input logic [7:0] dl, input logic [7:0] m);
    HOST.start();
    chk(download_active, 1'b1);
    HOST.send_cfg(m, g, c, dl, {dl, c, g}, {4'h0, g[3:0], m});
    HOST.finish();
    chk(download_active, 1'b0);
    chk(irq_map, prev_irq);
    HOST.apply();
    repeat (60) @(negedge clk_sys);
    prev_irq = {dl, c, g};
    chk(irq_map, prev_irq);
    chk(dma_map, {g[3:0], m});
    chk(internal_synth_enable, g[7]);
    chk(patch_load_enable, c == OWN_CODE);
    chk(ctrl_or_addr2_pin_is_addr, dl == 8'h08);
    chk(periph_decode_len, (dl == 8'h08) ? 4'h8 : 4'h4);
    periph_rd = 1'b1;
    serial_port_enable = 1'b1;
    synth_vol_wr = 1'b1;
    #1;
    chk(host_data_drive_en, !(g[3] || g[2]));
    chk(dsp_port_on_mid_pins, g[2]);
    chk(mid_pins_serial, g[2]);
    chk(high_pins_wavetable, g[3]);
    chk(alt_line_vol_wr, !g[4]);
    @(negedge clk_sys);
    periph_rd = 1'b0;
    serial_port_enable = 1'b0;
    synth_vol_wr = 1'b0;
  endtask
  task automatic t_vol(input logic [1:0] fmt, input logic volume_pins_enable);
    if (!volume_pins_enable) begin
      press(1, 1, 0);
      chk(volume_muted, 1'b0);
      tap(1, 0, 0, 0, 0);
    end else case (fmt)
      hwcfg_pkg::HWCFG_VOL_LEVEL: begin
        vol_mute_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(volume_muted, 1'b1);
        vol_mute_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(volume_muted, 1'b0);
      end
      hwcfg_pkg::HWCFG_VOL_TOGGLE: begin
        press(0, 0, 1);
        chk(volume_muted, 1'b1);
        press(0, 0, 1);
        chk(volume_muted, 1'b0);
        press(0, 0, 1);
        press(1, 0, 0);
        chk(volume_muted, 1'b0);
      end
      hwcfg_pkg::HWCFG_VOL_TWO: begin
        press(0, 0, 1);
        chk(volume_muted, 1'b0);
        press(1, 1, 0);
        chk(volume_muted, 1'b1);
        press(0, 1, 0);
        chk(volume_muted, 1'b0);
        tap(1, 0, 0, 1, 0);
        tap(0, 1, 0, 0, 1);
      end
      default: begin
        press(0, 1, 1);
        chk(volume_muted, 1'b1);
        press(1, 0, 0);
        chk(volume_muted, 1'b1);
        press(0, 0, 1);
        chk(volume_muted, 1'b0);
        tap(1, 0, 0, 0, 0);
        tap(0, 0, 1, 1, 0);
      end
    endcase
  endtask
  initial begin
    t_rerst();
    t_unlock();
    for (int i = 0; i < 5; i++) begin
      t_cfg(tg[i], tc[i], td[i], tm[i]);
      t_vol(tg[i][6:5], tm[i][2]);
    end
    t_rerst();
    summarize();
  end
endmodule

// ===== verilog/hwcfg_defines.svh
// Purpose: constants of the configuration loader
// Assumes: byte-wide host writes, synchronous reset
// Notes: config image indices count from the first byte after the eeprom header
`ifndef HWCFG_DEFINES_SVH
`define HWCFG_DEFINES_SVH
`define HWCFG_KEY_ADDR 16'h0279
`define HWCFG_CMD_OFS 3'h5
`define HWCFG_END_OFS 3'h6
`define HWCFG_BASE_RST 16'h0120
`define HWCFG_KEY_LEN 6'd32
`define HWCFG_CMD_ROM 8'h57
`define HWCFG_CMD_DL 8'hAA
`define HWCFG_CMD_APPLY 8'h5A
`define HWCFG_END_VAL 8'h00
`define HWCFG_SEQ0 8'h15
`define HWCFG_SEQ1 8'h02
`define HWCFG_SEQ2 8'h47
`define HWCFG_SEQ5 8'h33
`define HWCFG_SEQ6 8'h01
`define HWCFG_SEQ7 8'h79
`define HWCFG_RAM_BASE 16'h4000
`define HWCFG_RAM_AW 9
`define HWCFG_CFG_N 5'd19
`define HWCFG_IDX_MISC 5'd2
`define HWCFG_IDX_GLOB 5'd3
`define HWCFG_IDX_CODE 5'd4
`define HWCFG_IDX_DLEN 5'd12
`define HWCFG_IDX_IRQ0 5'd14
`define HWCFG_IDX_DMA0 5'd17
`define HWCFG_IDX_DMA1 5'd18
`define HWCFG_DLEN8 8'h08
`define HWCFG_MISC_VOLUME_PINS_ENABLE 2
`define HWCFG_GLOB_IFM 7
`define HWCFG_GLOB_VCF 5
`define HWCFG_GLOB_ALT_LINE_VOLUME_DISABLE 4
`define HWCFG_GLOB_WAVETABLE_PORT_ENABLE 3
`define HWCFG_GLOB_SPS 2
`define HWCFG_MISC_RST 8'h80
`define HWCFG_GLOB_RST 8'h00
`define HWCFG_DLEN_RST 8'h00
`define HWCFG_IRQ_RST 24'hFCB975
`define HWCFG_DMA_RST 12'h310
`define HWCFG_FIFO_W 8
`define HWCFG_FIFO_D 32
`endif

// ===== verilog/hwcfg_fifo.sv
// Purpose: byte fifo in front of the resource ram
// Assumes: depth a power of two
// Notes: honest full and empty
`timescale 1ns/1ps
module hwcfg_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q, rp_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_q[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// ===== verilog/hwcfg_hostload.sv
// Purpose: hardware configuration interpreter and host download engine
// Assumes: one-cycle io write strobes from the isa front end; button inputs debounced, active low
// Notes: config bytes are picked up from ram by a scan after an apply command
// Notes on behaviour
// - serial port switch routes dsp serial port to mid peripheral data pins
// - switch or wavetable bit set stops host data drive on peripheral reads
// - wavetable bit turns high peripheral data pins into wavetable serial port
// - alt line disable clear lets synth volume writes update alt line volume
// - format 00 mutes while mute input is low
// - format 01 mute press toggles, up or down press unmutes
// - format 10 ignores mute, up plus down mutes, either alone unmutes
// - format 11 ignores up, mute pin acts as up, else two-button
// - internal synth bit enables the internal fm synthesizer
// - code base byte mismatch suppresses the firmware patch load
// - decode byte 0 gives control pin and 4 locations, 08h gives 8
// - bytes 19 to 21 map interrupt pins, low nibble earlier pin
// - bytes 22 and 23 map dma pin pairs, low nibble first
// - after key, eight-byte sequence at key address sets control base
// - AAh, then start address low then high, then data stored into ram
// - 00h to end port leaves download mode
// - 5Ah to command port applies new hardware configuration
// - volume pins act only while volume enable bit is set
`timescale 1ns/1ps
`include "hwcfg_defines.svh"
module hwcfg_hostload (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [31:0] key_value,
  input wire logic [7:0] key_byte_expected,
  input wire logic [7:0] own_code_base,
  input wire logic periph_rd,
  input wire logic serial_port_enable,
  input wire logic synth_vol_wr,
  input wire logic vol_up_n,
  input wire logic vol_down_n,
  input wire logic vol_mute_n,
  output logic [15:0] control_port_base,
  output logic download_active,
  output logic cfg_busy,
  output logic host_data_drive_en,
  output logic dsp_port_on_mid_pins,
  output logic mid_pins_serial,
  output logic high_pins_wavetable,
  output logic alt_line_vol_wr,
  output logic internal_synth_enable,
  output logic patch_load_enable,
  output logic ctrl_or_addr2_pin_is_addr,
  output logic [3:0] periph_decode_len,
  output logic [23:0] irq_map,
  output logic [11:0] dma_map,
  output logic volume_muted,
  output logic vol_up_pulse,
  output logic vol_down_pulse
);
  hwcfg_pkg::hwcfg_state_t st_q, st_d;
  logic [5:0] key_cnt_q;
  logic key_ok_q;
  logic [2:0] seq_q;
  logic [7:0] base_hi_q;
  logic [15:0] base_q;
  logic [15:0] addr_q;
  logic [7:0] adlo_q;
  logic [`HWCFG_RAM_AW-1:0] wptr_q;
  logic scan_q;
  logic [4:0] scan_idx_q;
  logic scan_vld_q;
  logic [4:0] scan_cap_q;
  logic [7:0] misc_q, glob_q, code_q, dlen_q;
  logic [23:0] irq_q;
  logic [11:0] dma_q;
  logic muted_q;
  logic [2:0] btn_q;
  logic [7:0] rdata;
  hwcfg_stream_if fin ();
  hwcfg_stream_if fout ();

  // key and base sequence at the fixed key address
  wire key_wr = io_wr && io_addr == `HWCFG_KEY_ADDR;
  wire key_hit = io_wdata == key_byte_expected;
  wire ctl_wr = io_wr && io_addr[15:3] == base_q[15:3];
  wire cmd_wr = ctl_wr && io_addr[2:0] == `HWCFG_CMD_OFS;
  wire end_wr = ctl_wr && io_addr[2:0] == `HWCFG_END_OFS && io_wdata == `HWCFG_END_VAL;

  function automatic logic seq_match(input logic [2:0] idx, input logic [7:0] b);
    unique case (idx)
      3'h0: seq_match = b == `HWCFG_SEQ0;
      3'h1: seq_match = b == `HWCFG_SEQ1;
      3'h2: seq_match = b == `HWCFG_SEQ2;
      3'h5: seq_match = b == `HWCFG_SEQ5;
      3'h6: seq_match = b == `HWCFG_SEQ6;
      3'h7: seq_match = b == `HWCFG_SEQ7;
      default: seq_match = 1'b1;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      key_cnt_q <= '0;
      key_ok_q <= 1'b0;
      seq_q <= '0;
      base_hi_q <= '0;
      base_q <= `HWCFG_BASE_RST;
    end else if (key_wr) begin
      if (!key_ok_q) begin
        // count restarts once the key is whole, so a later unlock still works
        key_cnt_q <= (key_hit && key_cnt_q != `HWCFG_KEY_LEN - 6'd1) ? key_cnt_q + 6'd1 : 6'd0;
        key_ok_q <= key_hit && key_cnt_q == `HWCFG_KEY_LEN - 6'd1;
      end else if (!seq_match(seq_q, io_wdata)) begin
        seq_q <= '0;
      end else begin
        seq_q <= seq_q + 3'd1;
        if (seq_q == 3'h3) base_hi_q <= io_wdata;
        if (seq_q == 3'h4) base_q <= {base_hi_q, io_wdata};
        if (seq_q == 3'h7) key_ok_q <= 1'b0;
      end
    end
  end
  assign control_port_base = base_q;

  // command port state machine
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      hwcfg_pkg::HWCFG_IDLE: begin
        if (cmd_wr && io_wdata == `HWCFG_CMD_ROM) st_d = hwcfg_pkg::HWCFG_ROM;
        if (cmd_wr && io_wdata == `HWCFG_CMD_DL) st_d = hwcfg_pkg::HWCFG_ADLO;
      end
      hwcfg_pkg::HWCFG_ROM: begin
        if (cmd_wr && io_wdata == `HWCFG_CMD_DL) st_d = hwcfg_pkg::HWCFG_ADLO;
      end
      hwcfg_pkg::HWCFG_ADLO: if (cmd_wr) st_d = hwcfg_pkg::HWCFG_ADHI;
      hwcfg_pkg::HWCFG_ADHI: if (cmd_wr) st_d = hwcfg_pkg::HWCFG_DATA;
      hwcfg_pkg::HWCFG_DATA: ;
    endcase
    if (end_wr) st_d = hwcfg_pkg::HWCFG_IDLE;
  end
  always_ff @(posedge clk_sys) begin
    st_q <= sys_rst ? hwcfg_pkg::HWCFG_IDLE : st_d;
  end

  // download bytes go through the fifo into ram
  wire dl_byte = cmd_wr && st_q == hwcfg_pkg::HWCFG_DATA;
  assign fin.valid = dl_byte;
  assign fin.data = io_wdata;
  assign download_active = st_q != hwcfg_pkg::HWCFG_IDLE;
  // a full fifo would drop a byte; host must poll this before writing
  assign cfg_busy = !fin.ready || scan_q;

  hwcfg_fifo #(.W(`HWCFG_FIFO_W), .D(`HWCFG_FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(fin.valid),
    .in_ready(fin.ready),
    .in_data(fin.data),
    .out_valid(fout.valid),
    .out_ready(fout.ready),
    .out_data(fout.data)
  );
  // the scan owns the ram read port, so drain stalls during it
  assign fout.ready = !scan_q;

  wire ram_we = fout.valid && fout.ready;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adlo_q <= '0;
      addr_q <= `HWCFG_RAM_BASE;
    end else if (cmd_wr && st_q == hwcfg_pkg::HWCFG_ADLO) begin
      adlo_q <= io_wdata;
    end else if (cmd_wr && st_q == hwcfg_pkg::HWCFG_ADHI) begin
      addr_q <= {io_wdata, adlo_q};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wptr_q <= '0;
    end else if (cmd_wr && st_q == hwcfg_pkg::HWCFG_ADHI) begin
      wptr_q <= '0;
    end else if (ram_we) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  wire [15:0] wr_addr = addr_q - `HWCFG_RAM_BASE + {7'h00, wptr_q};
  hwcfg_ram u_ram (
    .clk_sys(clk_sys),
    .we(ram_we),
    .waddr(wr_addr[`HWCFG_RAM_AW-1:0]),
    .wdata(fout.data),
    .raddr(scan_idx_q[4:0] == 5'd0 ? '0 : {4'h0, scan_idx_q}),
    .rdata(rdata)
  );

  // apply: wait for fifo drain, then scan the first config bytes
  logic apply_pend_q;
  wire cmd_state = st_q == hwcfg_pkg::HWCFG_IDLE || st_q == hwcfg_pkg::HWCFG_ROM;
  // address and data bytes may be 5Ah too, so apply is decoded only between downloads
  wire apply_cmd = cmd_wr && io_wdata == `HWCFG_CMD_APPLY && cmd_state;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      apply_pend_q <= 1'b0;
      scan_q <= 1'b0;
      scan_idx_q <= '0;
      scan_vld_q <= 1'b0;
      scan_cap_q <= '0;
    end else begin
      if (apply_pend_q && !fout.valid && !scan_q) begin
        apply_pend_q <= 1'b0;
        scan_q <= 1'b1;
        scan_idx_q <= '0;
      end
      // a fresh apply beats the clear
      if (apply_cmd) apply_pend_q <= 1'b1;
      if (scan_q) begin
        scan_idx_q <= scan_idx_q + 5'd1;
        if (scan_idx_q == `HWCFG_CFG_N - 5'd1) scan_q <= 1'b0;
      end
      scan_vld_q <= scan_q;
      scan_cap_q <= scan_idx_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      misc_q <= `HWCFG_MISC_RST;
      glob_q <= `HWCFG_GLOB_RST;
      code_q <= '0;
      dlen_q <= `HWCFG_DLEN_RST;
      irq_q <= `HWCFG_IRQ_RST;
      dma_q <= `HWCFG_DMA_RST;
    end else if (scan_vld_q) begin
      unique case (scan_cap_q)
        `HWCFG_IDX_MISC: misc_q <= rdata;
        `HWCFG_IDX_GLOB: glob_q <= rdata;
        `HWCFG_IDX_CODE: code_q <= rdata;
        `HWCFG_IDX_DLEN: dlen_q <= rdata;
        `HWCFG_IDX_IRQ0: irq_q[7:0] <= rdata;
        5'd15: irq_q[15:8] <= rdata;
        5'd16: irq_q[23:16] <= rdata;
        `HWCFG_IDX_DMA0: dma_q[7:0] <= rdata;
        `HWCFG_IDX_DMA1: dma_q[11:8] <= rdata[3:0];
        default: ;
      endcase
    end
  end

  // decoded configuration
  wire serial_port_switch = glob_q[`HWCFG_GLOB_SPS];
  wire wavetable_port_enable = glob_q[`HWCFG_GLOB_WAVETABLE_PORT_ENABLE];
  assign dsp_port_on_mid_pins = serial_port_switch;
  assign mid_pins_serial = serial_port_switch && serial_port_enable;
  assign high_pins_wavetable = wavetable_port_enable;
  assign host_data_drive_en = periph_rd && !(serial_port_switch || wavetable_port_enable);
  assign alt_line_vol_wr = synth_vol_wr && !glob_q[`HWCFG_GLOB_ALT_LINE_VOLUME_DISABLE];
  assign internal_synth_enable = glob_q[`HWCFG_GLOB_IFM];
  assign patch_load_enable = code_q == own_code_base;
  assign ctrl_or_addr2_pin_is_addr = dlen_q == `HWCFG_DLEN8;
  assign periph_decode_len = ctrl_or_addr2_pin_is_addr ? 4'd8 : 4'd4;
  assign irq_map = irq_q;
  assign dma_map = dma_q;

  // hardware volume buttons
  hwcfg_pkg::hwcfg_vol_t fmt;
  assign fmt = hwcfg_pkg::hwcfg_vol_t'(glob_q[`HWCFG_GLOB_VCF+:2]);
  wire volume_pins_enable = misc_q[`HWCFG_MISC_VOLUME_PINS_ENABLE];
  wire up_raw = volume_pins_enable && (fmt == hwcfg_pkg::HWCFG_VOL_MUTEUP ? !vol_mute_n : !vol_up_n);
  wire dn_raw = volume_pins_enable && !vol_down_n;
  wire mu_raw = volume_pins_enable && !vol_mute_n;
  wire up_edge = up_raw && !btn_q[0];
  wire dn_edge = dn_raw && !btn_q[1];
  wire mu_edge = mu_raw && !btn_q[2];
  wire both = up_raw && dn_raw;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      btn_q <= '0;
      muted_q <= 1'b0;
    end else begin
      btn_q <= {mu_raw, dn_raw, up_raw};
      unique case (fmt)
        hwcfg_pkg::HWCFG_VOL_LEVEL: muted_q <= mu_raw;
        hwcfg_pkg::HWCFG_VOL_TOGGLE: begin
          if (up_edge || dn_edge) muted_q <= 1'b0;
          else if (mu_edge) muted_q <= !muted_q;
        end
        hwcfg_pkg::HWCFG_VOL_TWO, hwcfg_pkg::HWCFG_VOL_MUTEUP: begin
          if (both) muted_q <= 1'b1;
          else if (up_edge || dn_edge) muted_q <= 1'b0;
        end
      endcase
    end
  end
  assign volume_muted = muted_q;
  assign vol_up_pulse = up_edge && !dn_raw;
  assign vol_down_pulse = dn_edge && !up_raw;
  // are kept by the loading host
endmodule

// ===== verilog/hwcfg_pkg.sv
// Purpose: types of the configuration loader
// Assumes: nothing
// Notes: one-hot states
package hwcfg_pkg;
  typedef enum logic [4:0] {
    HWCFG_IDLE = 5'h01,
    HWCFG_ADLO = 5'h02,
    HWCFG_ADHI = 5'h04,
    HWCFG_DATA = 5'h08,
    HWCFG_ROM = 5'h10
  } hwcfg_state_t;
  typedef enum logic [1:0] {
    HWCFG_VOL_LEVEL = 2'h0,
    HWCFG_VOL_TOGGLE = 2'h1,
    HWCFG_VOL_TWO = 2'h2,
    HWCFG_VOL_MUTEUP = 2'h3
  } hwcfg_vol_t;
endpackage

// ===== verilog/hwcfg_ram.sv
// Purpose: internal resource ram
// Assumes: one write port, one registered read port
// Notes: read data from a register
`timescale 1ns/1ps
`include "hwcfg_defines.svh"
module hwcfg_ram (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [`HWCFG_RAM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [`HWCFG_RAM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [2**`HWCFG_RAM_AW];
  always_ff @(posedge clk_sys) begin
    if (we) mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ===== verilog/hwcfg_stream_if.sv
// Purpose: byte stream between loader, fifo and ram
// Assumes: valid/ready handshake
// Notes: a beat moves when valid and ready are both high
`timescale 1ns/1ps
interface hwcfg_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
